// ### rtl/pcd_map.svh
// Purpose: offsets, termination field values, reset values and command codes
// Assumes: included by bare name
// Notes:   definitions only
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH
`define PCD_CMD_OFFSET     8'h23
`define PCD_CMD_RESET      8'h00
`define PCD_CMD_WAKE       8'h11
`define PCD_CMD_DET_OFF    8'h22
`define PCD_CMD_DET_ON     8'h33
`define PCD_CMD_SNK_OFF    8'h44
`define PCD_CMD_SNK_ON     8'h55
`define PCD_CMD_SRC_OFF    8'h66
`define PCD_CMD_SRC_DEF    8'h77
`define PCD_CMD_SRC_HIGH   8'h88
`define PCD_CMD_SEEK       8'h99
`define PCD_CMD_RX_FINAL   8'hAA
`define PCD_CMD_RSV_C      8'hCC
`define PCD_CMD_RSV_D      8'hDD
`define PCD_CMD_RSV_E      8'hEE
`define PCD_CMD_IDLE       8'hFF
`define PCD_TERM_RP        2'h1
`define PCD_TERM_RD        2'h2
`endif

// ### rtl/pcd_pkg.sv
// Purpose: types for the port controller command decoder
// Assumes: nothing
// Notes:   state held as one packed struct
package pcd_pkg;
	typedef struct packed {
		logic [7:0] cmd;
		logic       det_en;
		logic       sinking;
		logic       sourcing;
		logic       src_high;
		logic       rx_armed;
		logic       tog_start;
		logic       tog_rp_first;
	} pcd_state_t;
endpackage

// ### rtl/pcd_decoder.sv
// Purpose: command register at 0x23 and its one-shot decoder
// Assumes: reg_wr_en is one cycle per completed byte write
// Notes:   status flags are owned here and exported as levels
//
// Overview of operation
// - eight-bit command register at 0x23, reads zero after reset
// - wake code accepted, no action
// - 0x22 disables bus-voltage detection, clears detect-enabled flag
// - 0x33 enables bus-voltage detection, sets detect-enabled flag
// - 0x44 clears sinking flag
// - 0x55 sets sinking flag and enables detection if sink capable
// - 0x66 clears sourcing and sourcing-high flags
// - 0x77 sets sourcing flag and enables detection if source capable
// - 0x99 starts role toggling when toggle enable is set
// - toggling starts with Rp for 01b fields, Rd for 10b fields
// - mismatched termination fields prevent toggling start
// - 0xAA arms receive-enable clear after next GoodCRC sent
// - reserved codes 0xCC, 0xDD, 0xEE do nothing
// - bus idle code accepted, no action
`timescale 1ns/1ps
`include "pcd_map.svh"
module pcd_decoder
	import pcd_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       sink_path_capable,
	input  wire logic       source_path_capable,
	input  wire logic       source_high_capable,
	input  wire logic       toggle_role_enable,
	input  wire logic [1:0] cc1_term_field,
	input  wire logic [1:0] cc2_term_field,
	input  wire logic       goodcrc_sent,
	output logic            power_detect_enabled,
	output logic            sinking_power,
	output logic            sourcing_power,
	output logic            sourcing_high_level,
	output logic            rx_final_armed,
	output logic            rx_enable_clear,
	output logic            toggle_start,
	output logic            toggle_rp_first
);
	pcd_state_t state_q;
	pcd_state_t state_d;
	logic       wr_hit;

	// one decode of the command offset, shared by write and read paths
	function automatic logic is_cmd_addr(input logic [7:0] addr);
		return addr == `PCD_CMD_OFFSET;
	endfunction

	// pulse only on the write strobe, never from the held value
	assign wr_hit = reg_wr_en && is_cmd_addr(reg_addr);

	always_comb begin
		state_d = state_q;
		state_d.tog_start = 1'b0;
		if (state_q.rx_armed && goodcrc_sent) begin
			state_d.rx_armed = 1'b0;
		end
		if (wr_hit) begin
			state_d.cmd = reg_wdata;
			case (reg_wdata)
				`PCD_CMD_WAKE: begin
					state_d.cmd = reg_wdata;
				end
				`PCD_CMD_DET_OFF: begin
					state_d.det_en = 1'b0;
				end
				`PCD_CMD_DET_ON: begin
					state_d.det_en = 1'b1;
				end
				`PCD_CMD_SNK_OFF: begin
					state_d.sinking = 1'b0;
				end
				`PCD_CMD_SNK_ON: begin
					if (sink_path_capable) begin
						state_d.sinking = 1'b1;
						state_d.det_en  = 1'b1;
					end
				end
				`PCD_CMD_SRC_OFF: begin
					state_d.sourcing = 1'b0;
					state_d.src_high = 1'b0;
				end
				`PCD_CMD_SRC_DEF: begin
					if (source_path_capable) begin
						state_d.sourcing = 1'b1;
						state_d.det_en   = 1'b1;
					end
				end
				`PCD_CMD_SRC_HIGH: begin
					if (source_high_capable) begin
						state_d.src_high = 1'b1;
					end
				end
				`PCD_CMD_SEEK: begin
					// restart hook for the port manager
					if (toggle_role_enable) begin
						if (cc1_term_field == `PCD_TERM_RP &&
						    cc2_term_field == `PCD_TERM_RP) begin
							state_d.tog_start    = 1'b1;
							state_d.tog_rp_first = 1'b1;
						end else if (cc1_term_field == `PCD_TERM_RD &&
						             cc2_term_field == `PCD_TERM_RD) begin
							state_d.tog_start    = 1'b1;
							state_d.tog_rp_first = 1'b0;
						end
						// any other field pair: no start
					end
				end
				`PCD_CMD_RX_FINAL: begin
					// arm wins over a same-cycle GoodCRC
					state_d.rx_armed = 1'b1;
				end
				`PCD_CMD_RSV_C, `PCD_CMD_RSV_D, `PCD_CMD_RSV_E: begin
					state_d.cmd = reg_wdata;
				end
				`PCD_CMD_IDLE: begin
					state_d.cmd = reg_wdata;
				end
				default: begin
					state_d.cmd = reg_wdata;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= '0;
			state_q.cmd <= `PCD_CMD_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// unmapped reads return zero
	assign reg_rdata = is_cmd_addr(reg_addr) ? state_q.cmd : 8'h00;
	assign power_detect_enabled = state_q.det_en;
	assign sinking_power        = state_q.sinking;
	assign sourcing_power       = state_q.sourcing;
	assign sourcing_high_level  = state_q.src_high;
	assign rx_final_armed       = state_q.rx_armed;
	assign rx_enable_clear      = state_q.rx_armed && goodcrc_sent;
	assign toggle_start         = state_q.tog_start;
	assign toggle_rp_first      = state_q.tog_rp_first;

	// reset checks run without disable, they watch the reset itself
	AST_RESET_ZERO: assert property (
		@(posedge clock)
		srst |=> (state_q.cmd == 8'h00))
		else $error("command register not zero after reset");
	AST_RESET_FLAGS: assert property (
		@(posedge clock)
		srst |=> !power_detect_enabled && !sinking_power &&
		!sourcing_power && !sourcing_high_level &&
		!rx_final_armed && !toggle_start)
		else $error("status flag set after reset");

	// register storage and read path
	AST_CMD_STORE: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit |=> state_q.cmd == $past(reg_wdata))
		else $error("written byte not stored");
	AST_CMD_HOLD: assert property (
		@(posedge clock) disable iff (srst)
		!wr_hit |=> $stable(state_q.cmd))
		else $error("command byte changed without a write");
	AST_UNMAPPED: assert property (
		@(posedge clock) disable iff (srst)
		reg_wr_en && !is_cmd_addr(reg_addr) |=> $stable(state_q.cmd))
		else $error("write to other offset reached the register");
	AST_RDATA_ZERO: assert property (
		@(posedge clock) disable iff (srst)
		!is_cmd_addr(reg_addr) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	// codes that only store the byte
	AST_WAKE_NOP: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_WAKE |=>
		$stable(power_detect_enabled) && $stable(sinking_power) &&
		$stable(sourcing_power) && $stable(sourcing_high_level))
		else $error("wake code changed a flag");
	AST_RSV_NOP: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && (reg_wdata == `PCD_CMD_RSV_C ||
		reg_wdata == `PCD_CMD_RSV_D || reg_wdata == `PCD_CMD_RSV_E) |=>
		$stable(power_detect_enabled) && $stable(sinking_power) &&
		$stable(sourcing_power) && !toggle_start)
		else $error("reserved code changed a flag");
	AST_IDLE_NOP: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_IDLE |=>
		$stable(power_detect_enabled) && $stable(sinking_power) &&
		$stable(sourcing_power) && $stable(sourcing_high_level))
		else $error("idle code changed a flag");
	AST_IGNORE: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h00 |=>
		$stable(power_detect_enabled) && $stable(sinking_power) &&
		$stable(sourcing_power))
		else $error("ignored code changed a flag");

	// detection and power path flags
	AST_DET_OFF: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h22 |=> !power_detect_enabled)
		else $error("detect still on after disable");
	AST_DET_ON: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h33 |=> power_detect_enabled)
		else $error("detect off after enable");
	AST_DET_HOLD: assert property (
		@(posedge clock) disable iff (srst)
		!wr_hit |=> $stable(power_detect_enabled))
		else $error("detect flag moved without a write");
	AST_SNK_OFF: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h44 |=> !sinking_power)
		else $error("sinking flag not cleared");
	AST_SNK_ON: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h55 |=>
		sinking_power == $past(sink_path_capable | sinking_power))
		else $error("sinking flag wrong after sink command");
	AST_SNK_DET: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_SNK_ON && sink_path_capable |=>
		power_detect_enabled)
		else $error("sink command left detection off");
	AST_SRC_OFF: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h66 |=>
		!sourcing_power && !sourcing_high_level)
		else $error("source flags not cleared");
	AST_SRC_ON: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h77 && source_path_capable |=>
		sourcing_power && power_detect_enabled)
		else $error("sourcing not set");
	AST_SRC_KEEP: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_SRC_DEF && !source_path_capable
		|=> $stable(sourcing_power))
		else $error("sourcing set without capability");
	AST_SRC_HIGH: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h88 && !source_high_capable |=>
		sourcing_high_level == $past(sourcing_high_level))
		else $error("high flag set without capability");
	AST_HIGH_SET: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_SRC_HIGH && source_high_capable
		|=> sourcing_high_level)
		else $error("high flag not set");
	AST_FLAG_HOLD: assert property (
		@(posedge clock) disable iff (srst)
		!wr_hit |=> $stable(sinking_power) && $stable(sourcing_power) &&
		$stable(sourcing_high_level))
		else $error("power flag moved without a write");

	// toggling start
	AST_TOG_ONCE: assert property (
		@(posedge clock) disable iff (srst)
		toggle_start |=> !toggle_start)
		else $error("toggle start longer than one cycle");
	AST_TOG_ONLY_SEEK: assert property (
		@(posedge clock) disable iff (srst)
		!(wr_hit && reg_wdata == `PCD_CMD_SEEK) |=> !toggle_start)
		else $error("toggle start without a seek write");
	AST_TOG_OFF: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_SEEK && !toggle_role_enable
		|=> !toggle_start)
		else $error("toggle started with toggling disabled");
	AST_TOG_RP: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_SEEK && toggle_role_enable &&
		cc1_term_field == 2'h1 && cc2_term_field == 2'h1 |=>
		toggle_start && toggle_rp_first)
		else $error("toggle did not start with Rp");
	AST_TOG_RD: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_SEEK && toggle_role_enable &&
		cc1_term_field == 2'h2 && cc2_term_field == 2'h2 |=>
		toggle_start && !toggle_rp_first)
		else $error("toggle did not start with Rd");
	AST_TOG_BAD: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == 8'h99 &&
		(cc1_term_field != cc2_term_field || !toggle_role_enable) |=>
		!toggle_start)
		else $error("toggle started with bad fields");

	// receiver stop after the next GoodCRC
	AST_ARM: assert property (
		@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_RX_FINAL |=> rx_final_armed)
		else $error("receiver not armed");
	AST_ARM_HOLD: assert property (
		@(posedge clock) disable iff (srst)
		rx_final_armed && !goodcrc_sent |=> rx_final_armed)
		else $error("receiver disarmed without GoodCRC");
	AST_RX_CLEAR: assert property (
		@(posedge clock) disable iff (srst)
		rx_enable_clear && !wr_hit |=> !rx_final_armed)
		else $error("receiver still armed after GoodCRC");
	AST_CLR_ONCE: assert property (
		@(posedge clock) disable iff (srst)
		rx_enable_clear && !wr_hit |=> !rx_enable_clear)
		else $error("receive clear pulsed twice");

	COV_SEEK_RP: cover property (@(posedge clock) disable iff (srst)
		toggle_start && toggle_rp_first);
	COV_SEEK_RD: cover property (@(posedge clock) disable iff (srst)
		toggle_start && !toggle_rp_first);
	COV_SINK: cover property (@(posedge clock) disable iff (srst)
		$rose(sinking_power));
	COV_RX: cover property (@(posedge clock) disable iff (srst)
		rx_enable_clear);
	// arm write meeting a GoodCRC in the same cycle
	COV_ARM_WINS: cover property (@(posedge clock) disable iff (srst)
		wr_hit && reg_wdata == `PCD_CMD_RX_FINAL && rx_enable_clear);
endmodule

// ### dv/pcd_host.sv
// Purpose: port manager host model, writes command bytes
// Assumes: design samples the strobe on the rising edge
// Notes:   drives on the falling edge, one byte per call
`timescale 1ns/1ps
module pcd_host (
	input  wire logic       clock,
	output logic      [7:0] reg_addr,
	output logic            reg_wr_en,
	output logic      [7:0] reg_wdata
);
	initial begin
		reg_addr  = 8'h23;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
	end
	// one call, one command; a reissued code runs again
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr  = a;
		reg_wr_en = 1'b1;
		reg_wdata = d;
		@(negedge clock);
		reg_wr_en = 1'b0;
		reg_wdata = ~d; // released data shows no stale byte
	endtask
endmodule

// ### dv/pcd_decoder_tb_top.sv
// Purpose: self-checking bench for the command decoder
// Assumes: effects show at the write edge, checked at the next falling edge
// Notes:   row = code, {snk,src,hi,tog}, {cc1,cc2}, flags
`timescale 1ns/1ps
module pcd_decoder_tb_top;
	logic        clock, srst, snk_cap, src_cap, hi_cap, tog_en, gcrc;
	logic [1:0]  cc1, cc2;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr_en, det, snk, src, hi, armed, rxclr, tst, rp;
	int          n_fail = 0;
	int          check_count = 0;
	logic [23:0] rows [22] = '{24'h330040, 24'h220000, 24'h550000,
		24'h558060, 24'h440040, 24'h220000, 24'h774050, 24'h882058,
		24'h660040, 24'h880040, 24'h991A42, 24'h991543, 24'h991641,
		24'h990541, 24'h110041, 24'hCC0041, 24'hDD0041, 24'hEE0041,
		24'hFF0041, 24'h000041, 24'h5A0041, 24'hAA0045};
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	pcd_host pcd_host_i (.clock(clock), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata));
	pcd_decoder pcd_decoder_i (.clock(clock), .srst(srst),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.sink_path_capable(snk_cap), .source_path_capable(src_cap),
		.source_high_capable(hi_cap), .toggle_role_enable(tog_en),
		.cc1_term_field(cc1), .cc2_term_field(cc2), .goodcrc_sent(gcrc),
		.power_detect_enabled(det), .sinking_power(snk),
		.sourcing_power(src), .sourcing_high_level(hi),
		.rx_final_armed(armed), .rx_enable_clear(rxclr),
		.toggle_start(tst), .toggle_rp_first(rp));
	task automatic chk(input string s, input logic [7:0] seen,
		input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [7:0] flags();
		return {1'b0, det, snk, src, hi, armed, tst, rp};
	endfunction
	initial begin
		srst = 1'b1;
		{snk_cap, src_cap, hi_cap, tog_en, gcrc} = 5'h00;
		{cc1, cc2} = 4'h0;
		repeat (6) @(negedge clock);
		srst = 1'b0;
		chk("reset rdata", reg_rdata, 8'h00);
		chk("reset flags", flags(), 8'h00);
		foreach (rows[i]) begin
			{snk_cap, src_cap, hi_cap, tog_en} = rows[i][15:12];
			{cc1, cc2} = rows[i][11:8];
			pcd_host_i.wr(8'h23, rows[i][23:16]);
			chk("flags", flags(), rows[i][7:0]);
			chk("rdata", reg_rdata, rows[i][23:16]);
			@(negedge clock);
			chk("pulse", {7'h00, tst}, 8'h00);
		end
		// arm left from the last row; clear is combinational
		gcrc = 1'b1;
		#1;
		chk("rx clear", {7'h00, rxclr}, 8'h01);
		@(negedge clock);
		gcrc = 1'b0;
		#1;
		chk("disarm", {6'h00, armed, rxclr}, 8'h00);
		@(negedge clock);
		gcrc = 1'b1;
		#1;
		chk("idle clear", {7'h00, rxclr}, 8'h00);
		@(negedge clock);
		gcrc = 1'b0;
		pcd_host_i.wr(8'h24, 8'h22);
		chk("unmapped", flags(), 8'h41);
		chk("rdata 24", reg_rdata, 8'h00);
		// arm, then arm again in the cycle of a GoodCRC: arm wins
		pcd_host_i.wr(8'h23, 8'hAA);
		chk("armed", flags(), 8'h45);
		fork
			pcd_host_i.wr(8'h23, 8'hAA);
			begin
				@(negedge clock);
				gcrc = 1'b1;
				#1;
				chk("clr on arm", {7'h00, rxclr}, 8'h01);
				@(negedge clock);
				gcrc = 1'b0;
			end
		join
		chk("rearmed", {7'h00, armed}, 8'h01);
		// reset in mid-run, then a write on the second cycle after release
		@(negedge clock);
		srst = 1'b1;
		@(negedge clock);
		srst = 1'b0;
		chk("mid reset flags", flags(), 8'h00);
		chk("mid reset rdata", reg_rdata, 8'h00);
		pcd_host_i.wr(8'h23, 8'h33);
		chk("after reset", flags(), 8'h40);
		finish_test();
	end
	initial begin
		repeat (2000) @(posedge clock);
		n_fail++;
		finish_test();
	end
endmodule
